//--- verilog/eesm_pkg.sv
// Purpose: constants shared by the encoder error and status monitor
// Assumes: 10 MHz clock, one processing cycle evaluates all fault causes
// Notes:   fault flag bit positions are the order of the cause list below
package eesm_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CYCLE_US      = 300;
  localparam int unsigned CYCLE_MAX_US  = 500;
  localparam int unsigned CYCLE_CYC     = (CYCLE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DYN_PERIOD_US = 4000;
  localparam int unsigned DYN_HALF_CYC  = (DYN_PERIOD_US * (CLK_HZ / 1_000_000)) / 2;
  localparam int unsigned FREEZE_US     = 20;
  localparam int unsigned UNFREEZE_US   = 100;
  localparam int unsigned UNFREEZE_CYC  = UNFREEZE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FREEZE_CYC    = FREEZE_US * (CLK_HZ / 1_000_000);

  localparam int unsigned NFAULT        = 8;
  localparam int unsigned F_COMPONENT   = 0;
  localparam int unsigned F_REVERSAL    = 1;
  localparam int unsigned F_JUMP        = 2;
  localparam int unsigned F_CHECKSUM    = 3;
  localparam int unsigned F_CAM_OVERRUN = 4;
  localparam int unsigned F_WARM        = 5;
  localparam int unsigned F_OVERSPEED   = 6;
  localparam int unsigned F_ANALOG      = 7;
  localparam logic [7:0]  OVERSPEED_MASK = 8'h40;

  localparam int unsigned SSI_SINGLE_W  = 32;
  localparam int unsigned SSI_MULTI_W   = 26;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [7:0]  RST_FAULTS    = 8'h00;
endpackage

//--- verilog/eesm_monitor.sv
// Purpose: fault detection, status bits and actual-value reporting
// Assumes: tool commands and data inputs come from logic on clk; latch and bus pins are asynchronous
// Notes:   jump, reversal, cam overrun and overspeed causes are sampled once per processing cycle
module eesm_monitor #(
  parameter int unsigned DYN_HALF = eesm_pkg::DYN_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] raw_pos,
  input  wire logic [31:0] cam_pos_in,
  input  wire logic [31:0] velocity_in,
  input  wire logic        linear_enc,
  input  wire logic [31:0] speed_limit,
  input  wire logic [31:0] jump_limit,
  input  wire logic [31:0] reversal_min,
  input  wire logic        selftest_done,
  input  wire logic        selftest_fail,
  input  wire logic        param_word_valid,
  input  wire logic [15:0] param_word,
  input  wire logic        param_last,
  input  wire logic [15:0] param_sum_stored,
  input  wire logic        cam_late,
  input  wire logic        port_check_ok,
  input  wire logic        ram_check_ok,
  input  wire logic        cal_valid,
  input  wire logic [15:0] cal_value,
  input  wire logic [15:0] cal_min,
  input  wire logic [15:0] cal_max,
  input  wire logic        tool_reset,
  input  wire logic        adj_valid,
  input  wire logic [31:0] adj_value,
  input  wire logic        adj_store,
  input  wire logic [31:0] ssi_data,
  input  wire logic        ssi_multi,
  input  wire logic [31:0] par_pattern,
  input  wire logic [31:0] short_det,
  input  wire logic        latch_pin,
  input  wire logic        bus_addr_pin,
  output logic             error_r,
  output logic             ready_relay_r,
  output logic             ready_bit_r,
  output logic             overspeed_r,
  output logic [7:0]       fault_flags_r,
  output logic             warm_restart_r,
  output logic             dyn_error_r,
  output logic             cycle_tick_r,
  output logic [31:0]      position_r,
  output logic [31:0]      cam_pos_r,
  output logic [31:0]      velocity_r,
  output logic             vel_mm_per_s_r,
  output logic [31:0]      offset_store_r,
  output logic             offset_store_stb_r,
  output logic             adj_unstored_r,
  output logic [31:0]      ssi_view_r,
  output logic [5:0]       ssi_width_r,
  output logic [31:0]      par_view_r,
  output logic [31:0]      short_nom0_r,
  output logic [31:0]      short_nom1_r,
  output logic             bus_addressed_r
);
  localparam logic [31:0] CYC_LAST  = 32'(eesm_pkg::CYCLE_CYC - 1);
  localparam logic [31:0] DYN_LAST  = 32'(DYN_HALF - 1);
  localparam logic [31:0] UNF_LAST  = 32'(eesm_pkg::UNFREEZE_CYC - 1);
  localparam int unsigned MPAD      = eesm_pkg::SSI_SINGLE_W - eesm_pkg::SSI_MULTI_W;

  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? (~v + 32'h0000_0001) : v;
  endfunction

  // Pin synchronisers
  logic [1:0] latch_sync_r;
  logic [1:0] bus_sync_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_sync_r <= 2'h0;
      bus_sync_r   <= 2'h0;
    end else begin
      latch_sync_r <= {latch_sync_r[0], latch_pin};
      bus_sync_r   <= {bus_sync_r[0], bus_addr_pin};
    end
  end
  wire logic latched = latch_sync_r[1];

  // Processing cycle timebase
  logic [31:0] cyc_cnt_r;
  wire  logic  cyc_end = (cyc_cnt_r == CYC_LAST);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_cnt_r    <= eesm_pkg::RST_WORD;
      cycle_tick_r <= 1'b0;
    end else begin
      cyc_cnt_r    <= cyc_end ? eesm_pkg::RST_WORD : cyc_cnt_r + 32'h0000_0001;
      cycle_tick_r <= cyc_end;
    end
  end

  // Position adjustment
  logic [31:0] offset_r;
  wire  logic [31:0] adj_pos = raw_pos + offset_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_r           <= eesm_pkg::RST_WORD;
      offset_store_r     <= eesm_pkg::RST_WORD;
      offset_store_stb_r <= 1'b0;
      adj_unstored_r     <= 1'b0;
    end else begin
      if (adj_valid) begin
        offset_r <= adj_value - raw_pos;
      end
      offset_store_stb_r <= adj_store;
      if (adj_store) begin
        offset_store_r <= adj_valid ? adj_value - raw_pos : offset_r;
      end
      adj_unstored_r <= adj_valid | (adj_unstored_r & ~adj_store);
    end
  end

  // Motion analysis, one sample per cycle
  logic [31:0] pos_prev_r;
  logic [31:0] delta_prev_r;
  logic        pos_seen_r;
  wire  logic [31:0] delta     = adj_pos - pos_prev_r;
  wire  logic [31:0] delta_mag = abs32(delta);
  wire  logic        jump_now  = pos_seen_r & (delta_mag > jump_limit) & ~adj_valid;
  wire  logic        rev_now   = pos_seen_r & (delta[31] != delta_prev_r[31]) &
                                 (delta_mag >= reversal_min) & (abs32(delta_prev_r) >= reversal_min);
  wire  logic        ovs_now   = abs32(velocity_in) > speed_limit;
  wire  logic [31:0] adj_shift = adj_value - raw_pos - offset_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_prev_r   <= eesm_pkg::RST_WORD;
      delta_prev_r <= eesm_pkg::RST_WORD;
      pos_seen_r   <= 1'b0;
    end else if (cyc_end) begin
      pos_prev_r   <= adj_valid ? adj_value : adj_pos;
      delta_prev_r <= pos_seen_r ? delta : eesm_pkg::RST_WORD;
      pos_seen_r   <= 1'b1;
    end else if (adj_valid) begin
      // Rebase so an adjustment between cycle ends never reads as a position step
      pos_prev_r <= pos_prev_r + adj_shift;
    end
  end

  // Parameter checksum accumulation
  logic [15:0] sum_r;
  logic        sum_bad_r;
  wire  logic [15:0] sum_final = sum_r + param_word;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sum_r     <= 16'h0000;
      sum_bad_r <= 1'b0;
    end else if (param_word_valid) begin
      sum_r <= param_last ? 16'h0000 : sum_final;
      if (param_last) begin
        sum_bad_r <= (sum_final != param_sum_stored);
      end
    end
  end

  // Checks: self-diagnosis on every selftest_done strobe, analog calibration at power-on only
  logic comp_bad_r;
  logic cal_bad_r;
  logic cal_done_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      comp_bad_r <= 1'b0;
      cal_bad_r  <= 1'b0;
      cal_done_r <= 1'b0;
    end else begin
      if (selftest_done) begin
        comp_bad_r <= selftest_fail;
      end
      // Only the power-on check counts; later strobes are ignored
      if (cal_valid && !cal_done_r) begin
        cal_bad_r  <= (cal_value < cal_min) | (cal_value > cal_max);
        cal_done_r <= 1'b1;
      end
    end
  end

  // Warm restart on implausible state
  wire logic state_bad = ~port_check_ok | ~ram_check_ok;
  logic      warm_seen_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      warm_restart_r <= 1'b0;
      warm_seen_r    <= 1'b0;
    end else begin
      warm_restart_r <= state_bad & ~warm_seen_r;
      // One pulse per episode; only a clean cycle end rearms it
      if (cyc_end) begin
        warm_seen_r <= state_bad;
      end else if (state_bad) begin
        warm_seen_r <= 1'b1;
      end
    end
  end

  // Fault flags; reversal is sticky, set beats the tool reset
  logic [7:0] faults_nxt;
  always_comb begin
    faults_nxt                          = fault_flags_r;
    faults_nxt[eesm_pkg::F_COMPONENT]   = comp_bad_r;
    faults_nxt[eesm_pkg::F_CHECKSUM]    = sum_bad_r;
    faults_nxt[eesm_pkg::F_ANALOG]      = cal_bad_r;
    faults_nxt[eesm_pkg::F_WARM]        = warm_seen_r | warm_restart_r;
    if (tool_reset) begin
      faults_nxt[eesm_pkg::F_REVERSAL] = 1'b0;
    end
    if (cyc_end) begin
      faults_nxt[eesm_pkg::F_JUMP]        = jump_now;
      faults_nxt[eesm_pkg::F_CAM_OVERRUN] = cam_late;
      faults_nxt[eesm_pkg::F_OVERSPEED]   = ovs_now;
      if (rev_now) begin
        faults_nxt[eesm_pkg::F_REVERSAL] = 1'b1;
      end
    end
  end

  wire logic any_error = |(faults_nxt & ~eesm_pkg::OVERSPEED_MASK);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_flags_r <= eesm_pkg::RST_FAULTS;
      error_r       <= 1'b0;
      ready_relay_r <= 1'b0;
      ready_bit_r   <= 1'b0;
      overspeed_r   <= 1'b0;
    end else begin
      fault_flags_r <= faults_nxt;
      error_r       <= any_error;
      ready_relay_r <= ~any_error;
      ready_bit_r   <= ~any_error;
      overspeed_r   <= faults_nxt[eesm_pkg::F_OVERSPEED];
    end
  end

  // Dynamic error square wave; idles low so a dead encoder never looks alive
  logic [31:0] dyn_cnt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dyn_cnt_r   <= eesm_pkg::RST_WORD;
      dyn_error_r <= 1'b0;
    end else if (!error_r) begin
      dyn_cnt_r   <= eesm_pkg::RST_WORD;
      dyn_error_r <= 1'b0;
    end else if (dyn_cnt_r == DYN_LAST) begin
      dyn_cnt_r   <= eesm_pkg::RST_WORD;
      dyn_error_r <= ~dyn_error_r;
    end else begin
      dyn_cnt_r <= dyn_cnt_r + 32'h0000_0001;
    end
  end

  // Latch freeze: immediate after sync, release after a settle count
  logic [31:0] unf_cnt_r;
  logic        frozen_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unf_cnt_r <= eesm_pkg::RST_WORD;
      frozen_r  <= 1'b0;
    end else if (latched) begin
      unf_cnt_r <= eesm_pkg::RST_WORD;
      frozen_r  <= 1'b1;
    end else if (frozen_r) begin
      unf_cnt_r <= unf_cnt_r + 32'h0000_0001;
      if (unf_cnt_r >= (UNF_LAST >> 1)) begin
        frozen_r <= 1'b0;
      end
    end
  end

  // Actual value views
  wire logic [31:0] ssi_just = ssi_multi ? {ssi_data[eesm_pkg::SSI_MULTI_W-1:0], {MPAD{1'b0}}}
                                         : ssi_data;
  wire logic [31:0] cam_view = (adj_pos == eesm_pkg::RST_WORD) ? eesm_pkg::RST_WORD : cam_pos_in;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      position_r      <= eesm_pkg::RST_WORD;
      cam_pos_r       <= eesm_pkg::RST_WORD;
      velocity_r      <= eesm_pkg::RST_WORD;
      vel_mm_per_s_r  <= 1'b0;
      ssi_view_r      <= eesm_pkg::RST_WORD;
      ssi_width_r     <= 6'h00;
      par_view_r      <= eesm_pkg::RST_WORD;
      short_nom0_r    <= eesm_pkg::RST_WORD;
      short_nom1_r    <= eesm_pkg::RST_WORD;
      bus_addressed_r <= 1'b0;
    end else begin
      position_r      <= adj_pos;
      cam_pos_r       <= cam_view;
      velocity_r      <= velocity_in;
      vel_mm_per_s_r  <= linear_enc;
      ssi_view_r      <= ssi_just;
      ssi_width_r     <= ssi_multi ? 6'(eesm_pkg::SSI_MULTI_W) : 6'(eesm_pkg::SSI_SINGLE_W);
      if (!(latched || frozen_r)) begin
        par_view_r <= par_pattern;
      end
      short_nom0_r    <= short_det & ~par_view_r;
      short_nom1_r    <= short_det & par_view_r;
      bus_addressed_r <= bus_sync_r[1];
    end
  end
endmodule

//--- verification/eesm_monitor_props.sv
// Purpose: concurrent checks on the status monitor ports
// Assumes: one clock domain, DYN_HALF equals the design's value
// Notes:   bound to every monitor instance below
module eesm_monitor_props #(
  parameter int unsigned DYN_HALF = eesm_pkg::DYN_HALF_CYC
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [31:0] ssi_data,
  input wire logic        ssi_multi,
  input wire logic [31:0] short_det,
  input wire logic        latch_pin,
  input wire logic        tool_reset,
  input wire logic        error_r,
  input wire logic        ready_relay_r,
  input wire logic        ready_bit_r,
  input wire logic        overspeed_r,
  input wire logic [7:0]  fault_flags_r,
  input wire logic        warm_restart_r,
  input wire logic        dyn_error_r,
  input wire logic [31:0] position_r,
  input wire logic [31:0] cam_pos_r,
  input wire logic [31:0] ssi_view_r,
  input wire logic [5:0]  ssi_width_r,
  input wire logic [31:0] par_view_r,
  input wire logic [31:0] short_nom1_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] lj;
  logic        dyn_q_r;
  logic [15:0] dc_r;
  logic [7:0]  errs;
  assign lj = ssi_multi ? {ssi_data[25:0], 6'h00} : ssi_data;
  assign errs = fault_flags_r & ~eesm_pkg::OVERSPEED_MASK;
  // Restarts at 1 on a toggle so the first half period lines up with later ones
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dyn_q_r <= 1'b0;
      dc_r    <= 16'h0000;
    end else begin
      dyn_q_r <= dyn_error_r;
      dc_r    <= !error_r ? 16'h0000 : (dyn_error_r != dyn_q_r) ? 16'h0001 : dc_r + 16'h0001;
    end
  end
  property p_err_set;   (|errs) |-> ##[0:1] error_r; endproperty
  property p_err_clr;   !(|errs) |-> ##[0:1] !error_r; endproperty
  property p_rdy_off;   error_r |-> !ready_relay_r && !ready_bit_r; endproperty
  property p_rdy_on;    !error_r [*2] |-> ready_relay_r && ready_bit_r; endproperty
  property p_ospd;      overspeed_r == fault_flags_r[eesm_pkg::F_OVERSPEED]; endproperty
  property p_rev_hold;  fault_flags_r[1] && !tool_reset && !$past(tool_reset) |=> fault_flags_r[1]; endproperty
  property p_warm;      warm_restart_r |=> !warm_restart_r; endproperty
  property p_cam0;      position_r == 32'h0 |-> cam_pos_r == 32'h0; endproperty
  property p_ssi;       1'b1 |=> ssi_view_r == $past(lj) && ssi_width_r == ($past(ssi_multi) ? 6'h1a : 6'h20);
  endproperty
  property p_short;     1'b1 |=> short_nom1_r == ($past(short_det) & $past(par_view_r)); endproperty
  property p_freeze;    latch_pin [*5] |=> $stable(par_view_r); endproperty
  property p_dyn;       error_r |-> ((dyn_error_r != dyn_q_r) ? dc_r == DYN_HALF : dc_r < DYN_HALF); endproperty
  a_err_set:   assert property (p_err_set) else $error("error bit missing for fault");
  a_err_clr:   assert property (p_err_clr) else $error("error bit stuck");
  a_rdy_off:   assert property (p_rdy_off) else $error("ready shown during error");
  a_rdy_on:    assert property (p_rdy_on) else $error("ready bit missing");
  a_ospd:      assert property (p_ospd) else $error("overspeed bit wrong");
  a_rev_hold:  assert property (p_rev_hold) else $error("reversal fault cleared by itself");
  a_warm:      assert property (p_warm) else $error("warm restart pulse too long");
  a_cam0:      assert property (p_cam0) else $error("cam position not zero");
  a_ssi:       assert property (p_ssi) else $error("serial view wrong");
  a_short:     assert property (p_short) else $error("short flag wrong");
  a_freeze:    assert property (p_freeze) else $error("parallel view moved while latched");
  a_dyn:       assert property (p_dyn) else $error("dynamic error period wrong");
  c_cam:       cover property (fault_flags_r[eesm_pkg::F_CAM_OVERRUN]);
  c_rev:       cover property ($rose(fault_flags_r[1]));
  c_dyn:       cover property (error_r && dyn_error_r != dyn_q_r);
endmodule

bind eesm_monitor eesm_monitor_props #(.DYN_HALF(DYN_HALF)) u_props (.*);

//--- verification/eesm_plc.sv
// Purpose: controller-side model driving the latch and bus-address pins
// Assumes: both pins are asynchronous to the monitor clock
// Notes:   odd skews keep pin edges away from clock edges
module eesm_plc (
  input  wire logic cmd_latch,
  input  wire logic cmd_bus,
  output logic      latch_pin,
  output logic      bus_addr_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    latch_pin = 1'b0;
    bus_addr_pin = 1'b0;
  end
  always @(cmd_latch) latch_pin <= #37 cmd_latch;
  always @(cmd_bus) bus_addr_pin <= #23 cmd_bus;
endmodule

//--- verification/tb_eesm_monitor.sv
// Purpose: self-checking bench for the status monitor
// Assumes: DYN_HALF shortened to 4 clocks
// Notes:   status word is compared once per processing cycle
module tb_eesm_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, linear_enc, selftest_done, selftest_fail, param_word_valid, param_last;
  logic        cam_late, port_check_ok, ram_check_ok, cal_valid, tool_reset, adj_valid, adj_store;
  logic        ssi_multi, latch_pin, bus_addr_pin, plc_latch, plc_bus, cycle_tick_r, bus_addressed_r;
  logic        error_r, ready_relay_r, ready_bit_r, overspeed_r, warm_restart_r, dyn_error_r;
  logic        vel_mm_per_s_r, offset_store_stb_r, adj_unstored_r;
  logic [7:0]  fault_flags_r;
  logic [5:0]  ssi_width_r;
  logic [15:0] param_word, param_sum_stored, cal_value, cal_min, cal_max;
  logic [31:0] raw_pos, cam_pos_in, velocity_in, speed_limit, jump_limit, reversal_min, adj_value;
  logic [31:0] ssi_data, par_pattern, short_det, position_r, cam_pos_r, velocity_r, offset_store_r;
  logic [31:0] ssi_view_r, par_view_r, short_nom0_r, short_nom1_r, a, b;
  logic [11:0] q[$];
  int          miscompares, checks, n, cyc_n, last_tick;
  eesm_monitor #(.DYN_HALF(4)) uut (.*);
  eesm_plc u_plc (.cmd_latch(plc_latch), .cmd_bus(plc_bus), .latch_pin(latch_pin), .bus_addr_pin(bus_addr_pin));
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, s, e);
    end
  endtask
  // Notes the status expected at the next cycle end; overspeed alone keeps ready
  task automatic cyc(input logic [7:0] f);
    logic e;
    e = |(f & ~eesm_pkg::OVERSPEED_MASK);
    q.push_back({e, !e, !e, f[eesm_pkg::F_OVERSPEED], f});
    @(posedge clk iff cycle_tick_r);
    #10;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tk(1);
    s = 1'b0;
  endtask
  task automatic pw(input logic [15:0] w, input logic l);
    param_word = w;
    param_last = l;
    pulse(param_word_valid);
    tk(1);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (!rst_b) last_tick = 0;
    if (cycle_tick_r === 1'b1) begin
      if (last_tick > 0) chk(cyc_n - last_tick, eesm_pkg::CYCLE_CYC);
      last_tick = cyc_n;
    end
    if (cycle_tick_r === 1'b1 && q.size() > 0)
      chk({error_r, ready_relay_r, ready_bit_r, overspeed_r, fault_flags_r}, q.pop_front());
    if (cyc_n == 80000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    {linear_enc, selftest_done, selftest_fail, param_word_valid, param_last, cam_late, cal_valid, tool_reset} = '0;
    {adj_valid, adj_store, ssi_multi, plc_latch, plc_bus, param_word, param_sum_stored, cal_value} = '0;
    {raw_pos, cam_pos_in, velocity_in, adj_value, ssi_data, par_pattern, short_det} = '0;
    {port_check_ok, ram_check_ok} = 2'h3;
    jump_limit = 32'h0000_03e8;
    reversal_min = 32'h0000_000a;
    cal_min = 16'h0100;
    cal_max = 16'h8000;
    rst_b = 1'b0;
    void'($urandom(32'h4c63));
    speed_limit = ($urandom() & 32'h000f_ffff) | 32'h0000_1000;
    tk(3);
    rst_b = 1'b1;
    cyc(8'h00);
    cam_late = 1'b1;
    cyc(8'h10);
    cam_late = 1'b0;
    cyc(8'h00);
    velocity_in = speed_limit + 32'h1;
    cyc(8'h40);
    velocity_in = ~speed_limit;
    cyc(8'h40);
    velocity_in = speed_limit;
    cyc(8'h00);
    raw_pos = 32'h0000_07d0;
    cyc(8'h04);
    cyc(8'h00);
    raw_pos = 32'h0000_0834;
    cyc(8'h00);
    raw_pos = 32'h0000_07d0;
    cyc(8'h02);
    cyc(8'h02);
    pulse(tool_reset);
    cyc(8'h00);
    selftest_fail = 1'b1;
    pulse(selftest_done);
    cyc(8'h01);
    selftest_fail = 1'b0;
    pulse(selftest_done);
    cyc(8'h00);
    a = $urandom();
    b = $urandom();
    for (int i = 0; i < 2; i++) begin
      param_sum_stored = a[15:0] + b[15:0] + 16'(1 - i);
      pw(a[15:0], 1'b0);
      pw(b[15:0], 1'b1);
      cyc(i ? 8'h00 : 8'h08);
    end
    // Rearm needs a clean cycle end, so each restart waits for a tick first
    for (int i = 0; i < 2; i++) begin
      @(posedge clk iff cycle_tick_r);
      #10;
      {port_check_ok, ram_check_ok} = i ? 2'h2 : 2'h1;
      n = 0;
      repeat (4) begin
        @(posedge clk);
        #10;
        n += warm_restart_r;
        {port_check_ok, ram_check_ok} = 2'h3;
      end
      chk(n, 1);
      chk(fault_flags_r[eesm_pkg::F_WARM], 1'b1);
      chk(error_r, 1'b1);
    end
    for (int i = 0; i < 8; i++) begin
      ssi_data = $urandom();
      ssi_multi = i[0];
      tk(1);
      chk(ssi_view_r, ssi_multi ? {ssi_data[25:0], 6'h00} : ssi_data);
      chk(ssi_width_r, ssi_multi ? 6'h1a : 6'h20);
    end
    a = $urandom();
    b = ~a;
    short_det = $urandom();
    par_pattern = a;
    tk(4);
    chk(par_view_r, a);
    chk(short_nom0_r, short_det & ~a);
    chk(short_nom1_r, short_det & a);
    plc_latch = 1'b1;
    tk(5);
    par_pattern = b;
    tk(150);
    chk(par_view_r, a);
    plc_latch = 1'b0;
    tk(520);
    chk(par_view_r, b);
    for (int i = 1; i >= 0; i--) begin
      plc_bus = i[0];
      tk(5);
      chk(bus_addressed_r, i[0]);
    end
    for (int i = 0; i < 2; i++) begin
      velocity_in = $urandom();
      linear_enc = i[0];
      tk(3);
      chk(velocity_r, velocity_in);
      chk(vel_mm_per_s_r, i[0]);
    end
    cam_pos_in = $urandom() | 32'h1;
    raw_pos = $urandom();
    tk(2);
    pulse(adj_valid);
    tk(1);
    chk(position_r, 32'h0);
    chk(cam_pos_r, 32'h0);
    chk(adj_unstored_r, 1'b1);
    pulse(adj_store);
    chk(offset_store_stb_r, 1'b1);
    chk(offset_store_r, adj_value - raw_pos);
    tk(2);
    chk(adj_unstored_r, 1'b0);
    chk(offset_store_stb_r, 1'b0);
    raw_pos = 32'h0;
    velocity_in = 32'h0;
    rst_b = 1'b0;
    tk(3);
    rst_b = 1'b1;
    cal_value = 16'h8001;
    pulse(cal_valid);
    cyc(8'h80);
    cal_value = 16'h0200;
    pulse(cal_valid);
    cyc(8'h80);
    stop_test();
  end
endmodule
